// file: design/autobaud_defs.svh
`ifndef AUTOBAUD_DEFS_SVH
`define AUTOBAUD_DEFS_SVH
`define CLK_HZ 100000000
`define MIN_BAUD 50
`define MAX_BAUD 38400
`define BIT_CNT_W 25
`define MIN_BIT_CYC ((`CLK_HZ + `MAX_BAUD - 1) / `MAX_BAUD)
`define MAX_BIT_CYC (`CLK_HZ / `MIN_BAUD)
`define CHR_SPACE 8'h20
`define CHR_XOFF 8'h13
`define CHR_XON 8'h11
`define CHR_GT 8'h3E
`define CHR_CR 8'h0D
`define CHR_LF 8'h0A
`define CHR_ZERO 8'h30
`define DATA_BITS 4'h8
`define BANNER_LEN 6'h18
`define WORDS_MAX 7'h40
`define SPACE_LOW_BITS 4'h6
`define STOP_MID_BITS 4'h9
`endif

// file: design/autobaud_pkg.sv
package autobaud_pkg;
	typedef enum logic [4:0] {
		ST_MEASURE = 5'h01,
		ST_WAIT_IDLE = 5'h02,
		ST_BANNER = 5'h04,
		ST_PROMPT = 5'h08,
		ST_READY = 5'h10
	} main_state_t;
endpackage

// file: design/banner_rom.sv
`timescale 1ns/1ps
`include "autobaud_defs.svh"

// Sign-on text; read data come out of a register.
module banner_rom
	import autobaud_pkg::*;
(
	input wire logic ref_clk, // Clock.
	input wire logic [5:0] addr, // Character index.
	output logic [7:0] data_q // Registered character.
);
	logic [7:0] rom_d;

	// Banner text: blank line, sign-on line, blank line.
	always_comb
	begin
		case (addr)
			6'h00: rom_d = `CHR_CR;
			6'h01: rom_d = `CHR_LF;
			6'h02: rom_d = 8'h42;
			6'h03: rom_d = 8'h41;
			6'h04: rom_d = 8'h53;
			6'h05: rom_d = 8'h49;
			6'h06: rom_d = 8'h43;
			6'h07: rom_d = 8'h20;
			6'h08: rom_d = 8'h4D;
			6'h09: rom_d = 8'h4F;
			6'h0A: rom_d = 8'h44;
			6'h0B: rom_d = 8'h55;
			6'h0C: rom_d = 8'h4C;
			6'h0D: rom_d = 8'h45;
			6'h0E: rom_d = 8'h20;
			6'h0F: rom_d = 8'h52;
			6'h10: rom_d = 8'h45;
			6'h11: rom_d = 8'h41;
			6'h12: rom_d = 8'h44;
			6'h13: rom_d = 8'h59;
			6'h14: rom_d = `CHR_CR;
			6'h15: rom_d = `CHR_LF;
			6'h16: rom_d = `CHR_CR;
			default: rom_d = `CHR_LF;
		endcase
	end

	// Registered read keeps the output free of decode glitches.
	always_ff @(posedge ref_clk)
	begin
		data_q <= rom_d;
	end
endmodule // banner_rom

// file: design/autobaud_console_uart.sv
`timescale 1ns/1ps
`include "autobaud_defs.svh"
// Overview of operation
// RULE1 - Console frames characters as 8 data bits, no parity, one stop bit.
// RULE2 - Rate detection and link work from 50 to 38400 baud.
// RULE3 - XON/XOFF flow control on transmit is active from reset; code decodes XOFF/XON only from ST_BANNER on, after lock.
// RULE4 - Bit time measured from first received character, assumed space code 32.
// RULE5 - After lock, sign-on text is sent at the detected rate.
// RULE6 - Console's first character must be a space.
// RULE7 - Prompt is selected program number followed by greater-than.
// RULE8 - Force flag selects startup mode zero at next power-up.
// RULE9 - Host input and output word counts are configurable up to 64.
// RULE10 - Consoles without flow control should use lower bit rates.
// RULE11 - Code 19 halts transmit; only code 17 resumes it.
// RULE12 - Locked rate is kept until reset; no re-detection.
module autobaud_console_uart
	import autobaud_pkg::*;
(
	input wire logic ref_clk, // 100 MHz clock.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic rxd, // Serial input from console.
	input wire logic [3:0] program_sel, // Selected program number.
	input wire logic force_mode0, // Force startup mode zero flag.
	input wire logic [3:0] stored_mode, // Stored startup selection.
	input wire logic [6:0] host_input_words_cfg, // Requested input word count.
	input wire logic [6:0] host_output_words_cfg, // Requested output word count.
	input wire logic [7:0] tx_data, // Application character to send.
	input wire logic tx_valid, // Application character offered.
	output logic tx_ready, // Application character taken.
	output logic [7:0] rx_data, // Received character.
	output logic rx_valid, // One-cycle pulse with rx_data.
	output logic txd, // Serial output to console.
	output logic baud_locked, // Bit rate has been locked.
	output logic cmd_ready, // Greater-than loaded into transmitter, ready for commands.
	output logic xoff_active, // Transmit halted by flow control.
	output logic [3:0] startup_mode, // Startup mode caught after reset.
	output logic [6:0] host_input_words, // Applied input word count.
	output logic [6:0] host_output_words // Applied output word count.
);
	typedef struct packed {
		logic rx_s1, rx_s2, rx_prev;
		main_state_t st;
		logic [`BIT_CNT_W-1:0] bit_cyc, meas;
		logic measuring;
		logic [3:0] low_bits;
		logic rx_busy;
		logic [`BIT_CNT_W-1:0] rx_cnt;
		logic [3:0] rx_bit;
		logic [7:0] rx_sh, rx_data;
		logic rx_valid;
		logic tx_busy;
		logic [`BIT_CNT_W-1:0] tx_cnt;
		logic [3:0] tx_bit;
		logic [8:0] tx_sh;
		logic txd, xoff, tx_ready;
		logic [5:0] ban_idx;
		logic ban_fetch;
		logic [1:0] pr_idx;
		logic cfg_done;
		logic [3:0] smode;
		logic [6:0] in_w, out_w;
		logic locked, cmd_rdy;
	} state_t;

	state_t s_q, s_d;
	logic [7:0] rom_q;
	logic rx_fall, send_req;
	logic [7:0] send_chr;

	banner_rom u_rom (
		.ref_clk(ref_clk),
		.addr(s_q.ban_idx),
		.data_q(rom_q)
	);

	// Clamp a word count to the documented maximum.
	function automatic logic [6:0] clamp_words(input logic [6:0] w);
		clamp_words = (w > `WORDS_MAX) ? `WORDS_MAX : w;
	endfunction

	// All next-state logic; the synchroniser's first stage is read only by the second.
	always_comb
	begin
		s_d = s_q;
		s_d.rx_s1 = rxd;
		s_d.rx_s2 = s_q.rx_s1;
		s_d.rx_prev = s_q.rx_s2;
		s_d.rx_valid = 1'b0;
		s_d.tx_ready = 1'b0;
		rx_fall = s_q.rx_prev & ~s_q.rx_s2;
		send_req = 1'b0;
		send_chr = `CHR_SPACE;
		// Power-up configuration caught once after reset release.
		if (!s_q.cfg_done)
		begin
			s_d.cfg_done = 1'b1;
			s_d.smode = force_mode0 ? 4'h0 : stored_mode; // RULE8
			s_d.in_w = clamp_words(host_input_words_cfg); // RULE9
			s_d.out_w = clamp_words(host_output_words_cfg); // RULE9
		end
		// Space is start bit plus five low data bits: six low bit times in one run.
		case (s_q.st)
			ST_MEASURE:
			begin
				if (!s_q.measuring && rx_fall)
				begin
					s_d.measuring = 1'b1;
					s_d.meas = '0;
				end
				else if (s_q.measuring)
				begin
					s_d.meas = s_q.meas + 1'b1;
					if (s_q.rx_s2)
					begin
						// The count stops one short of the run, so one is added back.
						s_d.bit_cyc = (s_q.meas + 1'b1) / `BIT_CNT_W'(`SPACE_LOW_BITS); // RULE4 RULE2
						s_d.measuring = 1'b0;
						s_d.st = ST_WAIT_IDLE;
					end
				end
			end
			ST_WAIT_IDLE:
			begin
				// Let the rest of the space pass so it is not taken as data.
				// Stop in mid stop bit: a character sent right after it must not be missed.
				s_d.meas = s_q.meas + 1'b1;
				if (s_q.meas >= s_q.bit_cyc * `BIT_CNT_W'(`STOP_MID_BITS) + (s_q.bit_cyc >> 1))
					s_d.st = ST_BANNER; // RULE5
			end
			ST_BANNER:
			begin
				if (!s_q.tx_busy && !s_q.xoff && !s_q.ban_fetch)
					s_d.ban_fetch = 1'b1;
				else if (s_q.ban_fetch)
				begin
					// A halt that lands during the fetch drops it; the same index is fetched again.
					s_d.ban_fetch = 1'b0;
					if (!s_q.xoff)
					begin
						send_req = 1'b1;
						send_chr = rom_q; // RULE5
						s_d.ban_idx = s_q.ban_idx + 1'b1;
						if (s_q.ban_idx == `BANNER_LEN - 1'b1)
							s_d.st = ST_PROMPT;
					end
				end
			end
			ST_PROMPT:
			begin
				if (!s_q.tx_busy && !s_q.xoff)
				begin
					send_req = 1'b1;
					send_chr = (s_q.pr_idx == 2'h0) ? (`CHR_ZERO + {4'h0, program_sel})
						: `CHR_GT; // RULE7
					s_d.pr_idx = s_q.pr_idx + 1'b1;
					if (s_q.pr_idx == 2'h1)
						s_d.st = ST_READY;
				end
			end
			ST_READY:
			begin
				if (!s_q.tx_busy && !s_q.xoff && tx_valid)
				begin
					send_req = 1'b1;
					send_chr = tx_data;
					s_d.tx_ready = 1'b1;
				end
			end
			default: s_d.st = ST_MEASURE;
		endcase
		// Receiver runs only after lock, at the locked rate.
		if (s_q.st != ST_MEASURE && s_q.st != ST_WAIT_IDLE)
		begin
			if (!s_q.rx_busy)
			begin
				if (rx_fall)
				begin
					s_d.rx_busy = 1'b1;
					s_d.rx_cnt = s_q.bit_cyc >> 1;
					s_d.rx_bit = 4'h0;
				end
			end
			else if (s_q.rx_cnt == '0)
			begin
				s_d.rx_cnt = s_q.bit_cyc - 1'b1;
				s_d.rx_bit = s_q.rx_bit + 1'b1;
				if (s_q.rx_bit == 4'h0 && s_q.rx_s2)
					s_d.rx_busy = 1'b0;
				else if (s_q.rx_bit == `DATA_BITS + 1'b1)
				begin
					s_d.rx_busy = 1'b0;
					if (s_q.rx_s2)
					begin
						if (s_q.rx_sh == `CHR_XOFF)
							s_d.xoff = 1'b1; // RULE11
						else if (s_q.rx_sh == `CHR_XON)
							s_d.xoff = 1'b0; // RULE11
						else
						begin
							s_d.rx_data = s_q.rx_sh; // RULE1
							s_d.rx_valid = 1'b1;
						end
					end
				end
				else if (s_q.rx_bit != 4'h0)
					s_d.rx_sh = {s_q.rx_s2, s_q.rx_sh[7:1]};
			end
			else
				s_d.rx_cnt = s_q.rx_cnt - 1'b1;
		end
		// Transmitter: 8N1 at the locked bit time; new characters wait on XOFF.
		if (send_req)
		begin
			s_d.tx_busy = 1'b1;
			s_d.tx_sh = {send_chr, 1'b0};
			s_d.tx_bit = 4'h0;
			s_d.tx_cnt = s_q.bit_cyc - 1'b1; // RULE3
			s_d.txd = 1'b0;
		end
		else if (s_q.tx_busy)
		begin
			if (s_q.tx_cnt == '0)
			begin
				s_d.tx_cnt = s_q.bit_cyc - 1'b1;
				s_d.tx_bit = s_q.tx_bit + 1'b1;
				s_d.tx_sh = {1'b1, s_q.tx_sh[8:1]};
				s_d.txd = s_q.tx_sh[1];
				if (s_q.tx_bit == `DATA_BITS + 1'b1)
				begin
					s_d.tx_busy = 1'b0;
					s_d.txd = 1'b1;
				end
			end
			else
				s_d.tx_cnt = s_q.tx_cnt - 1'b1;
		end
		// Status outputs are registered copies of the next state, so they track it exactly.
		s_d.locked = (s_d.st != ST_MEASURE); // RULE12
		s_d.cmd_rdy = (s_d.st == ST_READY); // RULE7
	end

	// Single state register; the measured rate is never cleared except by reset.
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			s_q <= '0;
			s_q.rx_s1 <= 1'b1;
			s_q.rx_s2 <= 1'b1;
			s_q.rx_prev <= 1'b1;
			s_q.st <= ST_MEASURE;
			s_q.txd <= 1'b1;
			s_q.tx_sh <= 9'h1FF;
		end
		else
			s_q <= s_d; // RULE12
	end

	assign tx_ready = s_q.tx_ready;
	assign rx_data = s_q.rx_data;
	assign rx_valid = s_q.rx_valid;
	assign txd = s_q.txd;
	assign baud_locked = s_q.locked;
	assign cmd_ready = s_q.cmd_rdy;
	assign xoff_active = s_q.xoff;
	assign startup_mode = s_q.smode;
	assign host_input_words = s_q.in_w;
	assign host_output_words = s_q.out_w;

	sequence start_tx_s;
		!s_q.tx_busy ##1 s_q.tx_busy;
	endsequence

	a_xoff_blocks_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_q.xoff && !s_q.tx_busy) |=> !s_q.tx_busy) // RULE11
		else $error("transmit started while halted");
	a_lock_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_q.st != ST_MEASURE) |=> $stable(s_q.bit_cyc)) // RULE12
		else $error("locked bit time changed");
	a_lock_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
		baud_locked |=> baud_locked) // RULE12
		else $error("lock lost");
	a_tx_frame_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
		start_tx_s |-> !txd) // RULE3
		else $error("start bit missing");
	a_words_max: assert property (@(posedge ref_clk) disable iff (!rst_n)
		host_input_words <= `WORDS_MAX && host_output_words <= `WORDS_MAX) // RULE9
		else $error("word count above maximum");
	a_force_mode0: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!s_q.cfg_done && force_mode0) |=> startup_mode == 4'h0) // RULE8
		else $error("forced mode zero not applied");
	a_prompt_gt: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_q.st == ST_PROMPT && s_d.st == ST_READY) |=> s_q.tx_sh[8:1] == `CHR_GT) // RULE7
		else $error("prompt lacks greater-than");
	a_banner_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_q.st == ST_READY) |-> s_q.ban_idx == `BANNER_LEN) // RULE5
		else $error("ready before banner complete");
	a_rate_range: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_q.st == ST_BANNER) |-> s_q.bit_cyc <= `BIT_CNT_W'(`MAX_BIT_CYC)) // RULE2
		else $error("bit time beyond slowest rate");
	a_measure_gap: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_q.st == ST_MEASURE && s_d.st == ST_WAIT_IDLE) |=> s_q.bit_cyc != '0) // RULE4
		else $error("zero bit time locked");
endmodule // autobaud_console_uart

// file: tb/console_terminal_model.sv
`timescale 1ns/1ps
// Terminal at the console end: sends 8N1 characters and decodes what comes back.
module console_terminal_model #(
	parameter int BIT_CYC = 2604 // Bit time in clock cycles, 38400 baud.
)
(
	input wire logic ref_clk, // Clock used only for timing.
	input wire logic txd, // Serial line from the device.
	output logic rxd, // Serial line to the device.
	output int rx_count, // Characters decoded from txd.
	output int frame_err, // Characters whose stop bit was low.
	output logic busy // A character on txd is being decoded.
);
	// The line idles high between characters, as a real terminal keeps it.
	// Mid-bit sampling at the terminal's own rate; a slow start is not forgiven.
	initial
	begin
		rxd = 1'b1;
		rx_count = 0;
		frame_err = 0;
		busy = 1'b0;
		forever
		begin
			@(negedge txd);
			busy = 1'b1;
			repeat (BIT_CYC / 2 + 9 * BIT_CYC) @(negedge ref_clk);
			if (txd !== 1'b1)
				frame_err++;
			rx_count++;
			busy = 1'b0;
		end
	end

	// One character, least significant bit first, changed on falling edges.
	task automatic send_char(input logic [7:0] ch);
		@(negedge ref_clk);
		rxd = 1'b0;
		repeat (BIT_CYC) @(negedge ref_clk);
		for (int i = 0; i < 8; i++)
		begin
			rxd = ch[i];
			repeat (BIT_CYC) @(negedge ref_clk);
		end
		rxd = 1'b1;
		repeat (BIT_CYC) @(negedge ref_clk);
	endtask
endmodule // console_terminal_model

// file: tb/autobaud_console_uart_tb_top.sv
`timescale 1ns/1ps
// Console-side checks of the auto-rate serial port.
module autobaud_console_uart_tb_top;
	localparam int BIT_CYC = 2604; // 38400 baud at 100 MHz.
	logic ref_clk, rst_n, rxd, force_mode0, tx_ready, rx_valid, txd;
	logic baud_locked, cmd_ready, xoff_active, busy, app_valid;
	logic [3:0] stored_mode, startup_mode, prog_sel;
	logic [6:0] in_cfg, out_cfg, in_words, out_words;
	logic [7:0] rx_data, last_rx, app_data;
	int error_cnt = 0, n_checks = 0, rx_seen = 0, tx_taken = 0, rx_count, frame_err;
	int halt_cnt = 0;

	autobaud_console_uart uut (
		.ref_clk(ref_clk), .rst_n(rst_n), .rxd(rxd), .program_sel(prog_sel),
		.force_mode0(force_mode0), .stored_mode(stored_mode),
		.host_input_words_cfg(in_cfg), .host_output_words_cfg(out_cfg),
		.tx_data(app_data), .tx_valid(app_valid), .tx_ready(tx_ready),
		.rx_data(rx_data), .rx_valid(rx_valid), .txd(txd), .baud_locked(baud_locked),
		.cmd_ready(cmd_ready), .xoff_active(xoff_active), .startup_mode(startup_mode),
		.host_input_words(in_words), .host_output_words(out_words));

	console_terminal_model #(.BIT_CYC(BIT_CYC)) term (
		.ref_clk(ref_clk), .txd(txd), .rxd(rxd), .rx_count(rx_count),
		.frame_err(frame_err), .busy(busy));

	// Free-running clock.
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Keep what the port reports, sampled mid-cycle where its outputs are settled.
	always @(negedge ref_clk)
	begin
		if (rx_valid === 1'b1)
		begin
			last_rx <= rx_data;
			rx_seen <= rx_seen + 1;
		end
		if (tx_ready === 1'b1)
			tx_taken <= tx_taken + 1;
	end

	task automatic tally_and_finish;
		$display("Checks %0d, errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// A bounded wait that ran out ends the run at once.
	task automatic guard(input logic ok);
		if (ok !== 1'b1)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, ok, 1'b1);
			tally_and_finish();
		end
	endtask

	task automatic do_reset;
		rst_n = 1'b0;
		repeat (8) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
	endtask

	// Settings caught after reset, with the force flag off and then on.
	task automatic test_startup;
		chk({4'h0, startup_mode}, 8'h05);
		chk({1'b0, in_words}, 8'h40);
		chk({1'b0, out_words}, 8'h0C);
		chk({7'h00, baud_locked}, 8'h00);
		chk({7'h00, txd}, 8'h01);
		force_mode0 = 1'b1;
		in_cfg = 7'h40;
		out_cfg = 7'h41;
		do_reset();
		chk({4'h0, startup_mode}, 8'h00);
		chk({1'b0, in_words}, 8'h40);
		chk({1'b0, out_words}, 8'h40);
	endtask

	// The space measures the rate; lock comes well before its stop bit ends.
	task automatic test_lock;
		term.send_char(8'h20);
		for (int i = 0; i < 2000 && baud_locked !== 1'b1; i++)
			@(negedge ref_clk);
		chk({7'h00, baud_locked}, 8'h01);
		chk({7'h00, xoff_active}, 8'h00);
	endtask

	// A later character that is not a space is data, not a new measurement.
	task automatic test_no_redetect;
		term.send_char(8'h41);
		repeat (4) @(negedge ref_clk);
		chk(last_rx, 8'h41);
		chk(rx_seen[7:0], 8'h01);
		chk({7'h00, baud_locked}, 8'h01);
	endtask

	// Halt the sign-on text mid-stream; only the character in flight may finish.
	task automatic test_halt;
		term.send_char(8'h13);
		chk({7'h00, xoff_active}, 8'h01);
		for (int i = 0; i < 30000 && busy; i++)
			@(negedge ref_clk);
		guard(!busy);
		halt_cnt = rx_count;
		guard(halt_cnt > 0);
	endtask

	// A whole received character of silence has passed while halted; then resume.
	// The run length at 38400 baud keeps the scenarios back to back, with no idle waits.
	task automatic test_resume;
		chk(8'(rx_count - halt_cnt), 8'h00);
		chk({7'h00, txd}, 8'h01);
		term.send_char(8'h11);
		chk({7'h00, xoff_active}, 8'h00);
		for (int i = 0; i < 3 * BIT_CYC && !busy; i++)
			@(negedge ref_clk);
		guard(busy);
		chk(frame_err[7:0], 8'h00);
		chk(rx_seen[7:0], 8'h01);
		chk(tx_taken[7:0], 8'h00);
	endtask

	// Main sequence; the first reset has the force flag clear.
	initial
	begin
		rst_n = 1'b0;
		force_mode0 = 1'b0;
		stored_mode = 4'h5;
		in_cfg = 7'h64;
		out_cfg = 7'h0C;
		prog_sel = 4'h3;
		app_data = 8'h55;
		app_valid = 1'b1;
		do_reset();
		test_startup();
		test_lock();
		test_halt();
		test_no_redetect();
		test_resume();
		tally_and_finish();
	end
endmodule // autobaud_console_uart_tb_top
